// ===== src/l1c_cache.sv
// Level one four-way cache with write buffer and nonblocking misses
`timescale 1ns/100ps
`default_nettype none
module l1c_cache
    import l1c_pkg::*;
#(
    parameter int WAY_KB = WAY_KB_DEF
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic EN_SECURE,
    input wire logic EN_NONSEC,
    input wire logic CPU_NS,
    input wire logic REPLACEMENT_POLICY_SELECT,
    input wire logic LOCKDOWN_WORLD_SHARE,
    input wire logic LOCK_WR,
    input wire logic LOCK_SEC_ACC,
    input wire logic [3:0] LOCK_WDATA,
    output logic [3:0] LOCK_RDATA,
    input wire logic RD_REQ,
    input wire logic RD_SEQ,
    input wire logic RD_DBL,
    input wire logic [31:0] RD_VADDR,
    input wire logic [31:0] RD_PADDR,
    input wire logic RD_NS,
    input wire logic RD_CACHEABLE,
    output logic RD_VALID,
    output logic RD_HIT,
    output logic [63:0] RD_DATA,
    output logic TAG_EN,
    output logic EVEN_EN,
    output logic ODD_EN,
    input wire logic WR_REQ,
    input wire logic WR_DBL,
    input wire logic [31:0] WR_VADDR,
    input wire logic [31:0] WR_PADDR,
    input wire logic WR_NS,
    input wire logic WR_CACHEABLE,
    input wire logic WR_WBACK,
    input wire logic [63:0] WR_DATA,
    output logic WR_READY,
    output logic WR_HIT,
    output logic MISS_VALID,
    output logic [1:0] MISS_SLOT,
    output logic [LINE_W-1:0] MISS_LINE,
    output logic EVICT_DIRTY,
    output logic [LINE_W-1:0] EVICT_LINE,
    input wire logic REFILL_VALID,
    input wire logic [1:0] REFILL_SLOT,
    input wire logic [1:0] REFILL_PAIR,
    input wire logic [63:0] REFILL_DATA,
    input wire logic REFILL_LAST
);
    localparam int SETS = WAY_KB * LINES_PER_KB;
    localparam int SW = $clog2(SETS);
    localparam int DW = SW + 2;

    if (WAY_KB < WAY_KB_MIN || WAY_KB > WAY_KB_MAX ||
        (WAY_KB & (WAY_KB - 1)) != 0) begin : g_bad
        $error("WAY_KB must be a power of two from 1 to 16");
    end

    l1c_tag_t tag_q [WAYS][SETS];
    logic [31:0] ev_q [WAYS][SETS*4];
    logic [31:0] od_q [WAYS][SETS*4];
    logic dirty_q [WAYS][SETS];
    l1c_wbe_t wb_q [WB_DEPTH];
    l1c_wbe_t wb_d [WB_DEPTH];
    l1c_slot_t slot_q [MISS_SLOTS];
    l1c_slot_t slot_d [MISS_SLOTS];
    l1c_slot_t rs;
    logic [3:0] lock_q, lock_d, lock_eff, lock_rd_q, lock_rd_d;
    logic [1:0] rr_q, rr_d, last_way_q, last_way_d;
    logic [1:0] vic, hway, wway, base, free_ix, wb_cnt_q, wb_cnt_d;
    logic [1:0] slot_cnt;
    logic [7:0] lfsr_q, lfsr_d;
    logic [LINE_W-1:0] last_va_q, last_va_d;
    logic last_hit_q, last_hit_d;
    logic [SW-1:0] rset, wset;
    logic [DW-1:0] rdi;
    logic [WAYS-1:0] whit, wvld, wwhit, wdirty;
    logic on, rd_go, seq, hitv, hit, pend, free_ok, alloc, by_pol;
    logic wacc, enq, ret;
    logic [63:0] rdata;
    logic rd_valid_q, rd_valid_d, rd_hit_q, rd_hit_d;
    logic [63:0] rd_data_q, rd_data_d;
    logic tag_en_q, tag_en_d, ev_en_q, ev_en_d, od_en_q, od_en_d;
    logic wr_rdy_q, wr_rdy_d, wr_hit_q, wr_hit_d;
    logic miss_q, miss_d, evd_q, evd_d;
    logic [1:0] mslot_q, mslot_d;
    logic [LINE_W-1:0] mline_q, mline_d, evl_q, evl_d;

    assign rset = RD_VADDR[OFS_W +: SW];
    assign wset = WR_VADDR[OFS_W +: SW];
    assign rdi = {rset, RD_VADDR[4:3]};
    assign rs = slot_q[REFILL_SLOT];

    for (genvar w = 0; w < WAYS; w++) begin : g_way
        l1c_tag_t rt;
        l1c_tag_t wt;
        assign rt = tag_q[w][rset];
        assign wt = tag_q[w][wset];
        assign wvld[w] = rt.vld;
        assign whit[w] = rt.vld && rt.ns == RD_NS &&
            rt.ptag == RD_PADDR[31:PTAG_LSB];
        assign wwhit[w] = wt.vld && wt.ns == WR_NS &&
            wt.ptag == WR_PADDR[31:PTAG_LSB];
    end

    always_comb begin
        on = CPU_NS ? EN_NONSEC : EN_SECURE;
        rd_go = RD_REQ && on;
        seq = RD_SEQ && last_hit_q &&
            RD_VADDR[31:OFS_W] == last_va_q;
        hway = last_way_q;
        if (!seq) begin
            hway = 2'h0;
            for (int w = WAYS - 1; w >= 0; w--)
                if (whit[w]) hway = WAY_W'(w);
        end
        hitv = seq || (|whit);
        hit = rd_go && RD_CACHEABLE && hitv;
        rdata = {od_q[hway][rdi], ev_q[hway][rdi]};
        for (int e = 0; e < WB_DEPTH; e++)
            if (wb_q[e].vld && wb_q[e].line == RD_PADDR[31:OFS_W] &&
                wb_q[e].pair == RD_VADDR[4:3]) begin
                if (wb_q[e].mask[0]) rdata[31:0] = wb_q[e].data[31:0];
                if (wb_q[e].mask[1]) rdata[63:32] = wb_q[e].data[63:32];
            end
        tag_en_d = rd_go && !seq;
        ev_en_d = rd_go && (RD_DBL || !RD_VADDR[2]);
        od_en_d = rd_go && (RD_DBL || RD_VADDR[2]);
        rd_valid_d = RD_REQ;
        rd_hit_d = hit;
        rd_data_d = {od_en_d ? rdata[63:32] : 32'h0,
            ev_en_d ? rdata[31:0] : 32'h0};
        last_va_d = rd_go ? RD_VADDR[31:OFS_W] : last_va_q;
        last_hit_d = rd_go ? hit : last_hit_q;
        if (REFILL_VALID && REFILL_LAST) last_hit_d = 1'b0;
        last_way_d = rd_go ? hway : last_way_q;
    end

    always_comb begin
        for (int w = 0; w < WAYS; w++) begin
            wdirty[w] = dirty_q[w][rset];
            for (int e = 0; e < WB_DEPTH; e++)
                if (wb_q[e].vld && wb_q[e].wback &&
                    wb_q[e].way == WAY_W'(w) &&
                    wb_q[e].set == SET_W_MAX'(rset)) wdirty[w] = 1'b1;
        end
        pend = 1'b0;
        free_ok = 1'b0;
        free_ix = 2'h0;
        slot_cnt = 2'h0;
        for (int s = MISS_SLOTS - 1; s >= 0; s--) begin
            if (slot_q[s].vld) slot_cnt = slot_cnt + 2'h1;
            if (slot_q[s].vld && slot_q[s].line == RD_PADDR[31:OFS_W])
                pend = 1'b1;
            if (!slot_q[s].vld) begin
                free_ok = 1'b1;
                free_ix = 2'(s);
            end
        end
        alloc = rd_go && RD_CACHEABLE && !hitv && !pend &&
            free_ok;
        lock_eff = (&lock_q) ? (lock_q & WAY0_FREE) : lock_q;
        base = REPLACEMENT_POLICY_SELECT ? rr_q : lfsr_q[1:0];
        vic = base;
        for (int k = WAYS - 1; k >= 0; k--)
            if (!lock_eff[2'(base + k)]) vic = 2'(base + k);
        by_pol = &(wvld | lock_eff);
        for (int w = WAYS - 1; w >= 0; w--)
            if (!wvld[w] && !lock_eff[w]) vic = WAY_W'(w);
        rr_d = rr_q;
        if (alloc && REPLACEMENT_POLICY_SELECT && by_pol)
            rr_d = vic + 2'h1;
        lfsr_d = {lfsr_q[6:0], ^(lfsr_q & LFSR_TAPS)};
        slot_d = slot_q;
        if (REFILL_VALID && REFILL_LAST) slot_d[REFILL_SLOT].vld = 1'b0;
        if (alloc) begin
            slot_d[free_ix].vld = 1'b1;
            slot_d[free_ix].way = vic;
            slot_d[free_ix].set = SET_W_MAX'(rset);
            slot_d[free_ix].line = RD_PADDR[31:OFS_W];
            slot_d[free_ix].ns = RD_NS;
        end
        miss_d = alloc;
        mslot_d = alloc ? free_ix : mslot_q;
        mline_d = alloc ? RD_PADDR[31:OFS_W] : mline_q;
        evd_d = alloc && wvld[vic] && wdirty[vic];
        evl_d = alloc ? {tag_q[vic][rset].ptag,
            rset[PTAG_LSB-OFS_W-1:0]} : evl_q;
        lock_d = lock_q;
        if (LOCK_WR && (LOCK_SEC_ACC || LOCKDOWN_WORLD_SHARE))
            lock_d = LOCK_WDATA;
        lock_rd_d = (LOCK_SEC_ACC || LOCKDOWN_WORLD_SHARE) ?
            lock_q : 4'h0;
    end

    always_comb begin
        wacc = WR_REQ && wr_rdy_q && on;
        wway = 2'h0;
        for (int w = WAYS - 1; w >= 0; w--)
            if (wwhit[w]) wway = WAY_W'(w);
        enq = wacc && WR_CACHEABLE && (|wwhit);
        ret = wb_q[0].vld && !REFILL_VALID;
        wb_d = wb_q;
        wb_cnt_d = wb_cnt_q;
        if (ret) begin
            for (int e = 0; e < WB_DEPTH - 1; e++)
                wb_d[e] = wb_q[e+1];
            wb_d[WB_DEPTH-1] = '0;
            wb_cnt_d = wb_cnt_q - 2'h1;
        end
        if (enq) begin
            wb_d[wb_cnt_d].vld = 1'b1;
            wb_d[wb_cnt_d].way = wway;
            wb_d[wb_cnt_d].set = SET_W_MAX'(wset);
            wb_d[wb_cnt_d].line = WR_PADDR[31:OFS_W];
            wb_d[wb_cnt_d].pair = WR_VADDR[4:3];
            wb_d[wb_cnt_d].mask = WR_DBL ? MASK_BOTH :
                (WR_VADDR[2] ? MASK_ODD : MASK_EVEN);
            wb_d[wb_cnt_d].data = WR_DATA;
            wb_d[wb_cnt_d].wback = WR_WBACK;
            wb_cnt_d = wb_cnt_d + 2'h1;
        end
        wr_rdy_d = wb_cnt_d < 2'(WB_DEPTH);
        wr_hit_d = enq;
    end

    // Storage arrays; only valid and dirty bits are cleared
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            for (int w = 0; w < WAYS; w++)
                for (int s = 0; s < SETS; s++) begin
                    tag_q[w][s].vld <= 1'b0;
                    dirty_q[w][s] <= 1'b0;
                end
        end else begin
            if (ret) begin
                if (wb_q[0].mask[0])
                    ev_q[wb_q[0].way][{wb_q[0].set[SW-1:0], wb_q[0].pair}]
                        <= wb_q[0].data[31:0];
                if (wb_q[0].mask[1])
                    od_q[wb_q[0].way][{wb_q[0].set[SW-1:0], wb_q[0].pair}]
                        <= wb_q[0].data[63:32];
                if (wb_q[0].wback)
                    dirty_q[wb_q[0].way][wb_q[0].set[SW-1:0]] <= 1'b1;
            end
            if (alloc) begin
                tag_q[vic][rset].vld <= 1'b0;
                dirty_q[vic][rset] <= 1'b0;
            end
            if (REFILL_VALID) begin
                ev_q[rs.way][{rs.set[SW-1:0], REFILL_PAIR}] <=
                    REFILL_DATA[31:0];
                od_q[rs.way][{rs.set[SW-1:0], REFILL_PAIR}] <=
                    REFILL_DATA[63:32];
                if (REFILL_LAST)
                    tag_q[rs.way][rs.set[SW-1:0]] <= '{vld: 1'b1,
                        ns: rs.ns, ptag: rs.line[LINE_W-1:OFS_W]};
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            for (int e = 0; e < WB_DEPTH; e++)
                wb_q[e] <= '0;
            for (int s = 0; s < MISS_SLOTS; s++)
                slot_q[s] <= '0;
            lock_q <= LOCK_RST;
            lock_rd_q <= 4'h0;
            rr_q <= RR_RST;
            lfsr_q <= LFSR_SEED;
            last_way_q <= 2'h0;
            last_va_q <= '0;
            last_hit_q <= 1'b0;
            wb_cnt_q <= 2'h0;
            rd_valid_q <= 1'b0;
            rd_hit_q <= 1'b0;
            rd_data_q <= 64'h0;
            tag_en_q <= 1'b0;
            ev_en_q <= 1'b0;
            od_en_q <= 1'b0;
            wr_rdy_q <= 1'b1;
            wr_hit_q <= 1'b0;
            miss_q <= 1'b0;
            mslot_q <= 2'h0;
            mline_q <= '0;
            evd_q <= 1'b0;
            evl_q <= '0;
        end else begin
            wb_q <= wb_d;
            slot_q <= slot_d;
            lock_q <= lock_d;
            lock_rd_q <= lock_rd_d;
            rr_q <= rr_d;
            lfsr_q <= lfsr_d;
            last_way_q <= last_way_d;
            last_va_q <= last_va_d;
            last_hit_q <= last_hit_d;
            wb_cnt_q <= wb_cnt_d;
            rd_valid_q <= rd_valid_d;
            rd_hit_q <= rd_hit_d;
            rd_data_q <= rd_data_d;
            tag_en_q <= tag_en_d;
            ev_en_q <= ev_en_d;
            od_en_q <= od_en_d;
            wr_rdy_q <= wr_rdy_d;
            wr_hit_q <= wr_hit_d;
            miss_q <= miss_d;
            mslot_q <= mslot_d;
            mline_q <= mline_d;
            evd_q <= evd_d;
            evl_q <= evl_d;
        end
    end

    assign LOCK_RDATA = lock_rd_q;
    assign RD_VALID = rd_valid_q;
    assign RD_HIT = rd_hit_q;
    assign RD_DATA = rd_data_q;
    assign TAG_EN = tag_en_q;
    assign EVEN_EN = ev_en_q;
    assign ODD_EN = od_en_q;
    assign WR_READY = wr_rdy_q;
    assign WR_HIT = wr_hit_q;
    assign MISS_VALID = miss_q;
    assign MISS_SLOT = mslot_q;
    assign MISS_LINE = mline_q;
    assign EVICT_DIRTY = evd_q;
    assign EVICT_LINE = evl_q;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    seq_no_tag_a: assert property (rd_go && seq && RD_CACHEABLE
        |=> !TAG_EN && RD_HIT)
        else $error("sequential read touched the tag RAM");
    half_ram_a: assert property (rd_go && !RD_DBL |=> EVEN_EN != ODD_EN)
        else $error("single word read enabled both RAMs");
    off_quiet_a: assert property (RD_REQ && !on |=> !RD_HIT && !TAG_EN)
        else $error("disabled cache was accessed");
    wb_full_a: assert property (wb_cnt_q == 2'd3 |-> !WR_READY)
        else $error("write accepted with full write buffer");
    retire_late_a: assert property (enq && wb_cnt_q == 2'd0 && !ret
        ##1 !REFILL_VALID |-> ret)
        else $error("buffered write not retired a cycle after hit");
    miss_cap_a: assert property (slot_cnt == 2'd3 |=> !MISS_VALID)
        else $error("fourth outstanding miss issued");
    lock_skip_a: assert property (alloc && lock_q != 4'hf |-> !lock_q[vic])
        else $error("victim in a locked way");
    all_lock_a: assert property (alloc && &lock_q |-> vic == 2'h0)
        else $error("all locked miss not sent to way zero");
    inval_first_a: assert property (alloc && !wvld[0] && !lock_q[0]
        |-> vic == 2'h0)
        else $error("lowest invalid way not chosen");
    rr_step_a: assert property (alloc && REPLACEMENT_POLICY_SELECT &&
        &wvld && lock_q == 4'h0 |=> rr_q == $past(rr_q) + 2'h1)
        else $error("round robin counter did not advance");
    wr_noalloc_a: assert property (wacc && !RD_REQ |=> !MISS_VALID)
        else $error("write miss allocated a line");
    lock_guard_a: assert property (LOCK_WR && !LOCK_SEC_ACC &&
        !LOCKDOWN_WORLD_SHARE |=> lock_q == $past(lock_q))
        else $error("non-secure lockdown write took effect");

    seq_read_c: cover property (rd_go && seq ##1 RD_HIT);
    dirty_evict_c: cover property (MISS_VALID && EVICT_DIRTY);
    wb_fill_c: cover property (wb_cnt_q == 2'd3);
endmodule // l1c_cache
`default_nettype wire

// ===== src/l1c_pkg.sv
// Constants and types of the level one set associative cache
// Contract
// - Four ways, virtual index, physical tag
// - Four ways; way size power of two
// - Eight words per line, fixed
// - Up to two words read per cycle
// - Stores go through three-entry write buffer
// - Reads compare pending write buffer addresses
// - One cycle between hit and RAM write
// - Dirty reads also check pending buffered writes
// - Separate dirty array set on retire, tags untouched
// - Victim way chosen when miss detected
// - Sequential same-line read skips tag RAM
// - Even/odd RAMs, one enabled for single
// - Lockdown per whole way
// - Random or round-robin, one shared counter; code keeps a separate LFSR and round-robin counter
// - Lowest invalid way filled first
// - Never allocate locked way unless all locked
// - All locked: treat way zero unlocked
// - Secure world tag stored and compared
// - Write-back or through from translation attributes
// - Allocate on read misses only
// - Separate secure and non-secure enables
// - Lockdown access gated by world share bit
// - Up to three outstanding data misses
// - Disabled cache is never accessed
package l1c_pkg;
    localparam int WAYS = 4;
    localparam int WAY_W = 2;
    localparam int LINE_WORDS = 8;
    localparam int OFS_W = 5;
    localparam int LINES_PER_KB = 1024 / (LINE_WORDS * 4);
    localparam int WB_DEPTH = 3;
    localparam int MISS_SLOTS = 3;
    localparam int WAY_KB_DEF = 16;
    localparam int WAY_KB_MIN = 1;
    localparam int WAY_KB_MAX = 16;
    localparam int PTAG_LSB = 10;
    localparam int PTAG_W = 22;
    localparam int LINE_W = 27;
    localparam int SET_W_MAX = 9;
    localparam logic [7:0] LFSR_SEED = 8'h5a;
    localparam logic [7:0] LFSR_TAPS = 8'hb8;
    localparam logic [3:0] LOCK_RST = 4'h0;
    localparam logic [3:0] WAY0_FREE = 4'he;
    localparam logic [1:0] RR_RST = 2'h0;
    localparam logic [1:0] MASK_EVEN = 2'h1;
    localparam logic [1:0] MASK_ODD = 2'h2;
    localparam logic [1:0] MASK_BOTH = 2'h3;

    typedef struct packed {
        logic vld;
        logic ns;
        logic [PTAG_W-1:0] ptag;
    } l1c_tag_t;

    typedef struct packed {
        logic vld;
        logic [WAY_W-1:0] way;
        logic [SET_W_MAX-1:0] set;
        logic [LINE_W-1:0] line;
        logic [1:0] pair;
        logic [1:0] mask;
        logic [63:0] data;
        logic wback;
    } l1c_wbe_t;

    typedef struct packed {
        logic vld;
        logic [WAY_W-1:0] way;
        logic [SET_W_MAX-1:0] set;
        logic [LINE_W-1:0] line;
        logic ns;
    } l1c_slot_t;
endpackage

// ===== bench/l1c_refill_model.sv
// Level two refill model answering the cache's line fill requests
`timescale 1ns/100ps
`default_nettype none
module l1c_refill_model
    import l1c_pkg::*;
#(
    parameter int GAP = 4
) (
    input wire logic clk,
    input wire logic miss_valid,
    input wire logic [1:0] miss_slot,
    input wire logic [LINE_W-1:0] miss_line,
    output logic refill_valid,
    output logic [1:0] refill_slot,
    output logic [1:0] refill_pair,
    output logic [63:0] refill_data,
    output logic refill_last,
    output logic busy
);
    logic [1:0] slot_q[$];
    logic [LINE_W-1:0] line_q[$];
    logic [LINE_W-1:0] ln;
    logic run = 1'b0;

    initial begin
        refill_valid = 1'b0;
        refill_slot = 2'h0;
        refill_pair = 2'h0;
        refill_data = 64'h0;
        refill_last = 1'b0;
        busy = 1'b0;
    end

    always @(posedge clk) begin
        if (miss_valid) begin
            slot_q.push_back(miss_slot);
            line_q.push_back(miss_line);
        end
        busy <= miss_valid || slot_q.size() != 0 || run;
    end

    // Requests served one line at a time, first beat held back by GAP
    always @(negedge clk) begin
        if (slot_q.size() != 0) begin
            run = 1'b1;
            ln = line_q.pop_front();
            refill_slot = slot_q.pop_front();
            repeat (GAP) @(negedge clk);
            for (int p = 0; p < 4; p++) begin
                refill_valid = 1'b1;
                refill_pair = 2'(p);
                refill_data = {2'h0, ln, 3'(2*p+1), 2'h0, ln, 3'(2*p)};
                refill_last = (p == 3);
                @(negedge clk);
            end
            refill_valid = 1'b0;
            refill_last = 1'b0;
            // Released data lines stop showing the last beat
            refill_data = ~refill_data;
            run = 1'b0;
        end
    end
endmodule // l1c_refill_model
`default_nettype wire

// ===== bench/l1c_cache_tb_top.sv
// Self-checking testbench of the level one cache
`timescale 1ns/100ps
`default_nettype none
module l1c_cache_tb_top
    import l1c_pkg::*;
;
    typedef struct packed {
        logic [31:0] pa;
        logic ns, ca, db, sq, hit, miss;
        logic [2:0] en;
    } l1c_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ens = 1'b1, enn = 1'b0, cns = 1'b0, rrp = 1'b1, lsh = 1'b0;
    logic lwr = 1'b0, lsa = 1'b1;
    logic [3:0] lwd = 4'h0;
    logic rq = 1'b0, rsq = 1'b0, rdb = 1'b0, rns = 1'b0, rca = 1'b1;
    logic [31:0] ra = 32'h0, wa = 32'h0;
    logic wq = 1'b0, wdb = 1'b0, wns = 1'b0, wca = 1'b1, wwb = 1'b1;
    logic [63:0] wd = 64'h0;
    logic [3:0] lrd;
    logic rv, rh, ten, een, oen, wr, wh, mv, ed, fv, fl, fb;
    logic [63:0] rdd, fd;
    logic [1:0] ms, fs, fp;
    logic [LINE_W-1:0] ml, el;
    int num_errors = 0, n_compared = 0, nm = 0;

    l1c_row_t rows [9] = '{
        '{32'h400, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0},
        '{32'h400, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h7},
        '{32'h40c, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h1},
        '{32'h400, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0},
        '{32'h410, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h6},
        '{32'h400, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0},
        '{32'h800, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0},
        '{32'hc00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0},
        '{32'h418, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h7}};

    always #20 clk = ~clk;

    l1c_cache #(.WAY_KB(1)) u_dut (
        .CLOCK(clk), .SRST(rst), .EN_SECURE(ens), .EN_NONSEC(enn),
        .CPU_NS(cns), .REPLACEMENT_POLICY_SELECT(rrp),
        .LOCKDOWN_WORLD_SHARE(lsh), .LOCK_WR(lwr), .LOCK_SEC_ACC(lsa),
        .LOCK_WDATA(lwd), .LOCK_RDATA(lrd), .RD_REQ(rq), .RD_SEQ(rsq),
        .RD_DBL(rdb), .RD_VADDR(ra), .RD_PADDR(ra), .RD_NS(rns),
        .RD_CACHEABLE(rca), .RD_VALID(rv), .RD_HIT(rh), .RD_DATA(rdd),
        .TAG_EN(ten), .EVEN_EN(een), .ODD_EN(oen), .WR_REQ(wq),
        .WR_DBL(wdb), .WR_VADDR(wa), .WR_PADDR(wa), .WR_NS(wns),
        .WR_CACHEABLE(wca), .WR_WBACK(wwb), .WR_DATA(wd),
        .WR_READY(wr), .WR_HIT(wh), .MISS_VALID(mv), .MISS_SLOT(ms),
        .MISS_LINE(ml), .EVICT_DIRTY(ed), .EVICT_LINE(el),
        .REFILL_VALID(fv), .REFILL_SLOT(fs), .REFILL_PAIR(fp),
        .REFILL_DATA(fd), .REFILL_LAST(fl));

    l1c_refill_model #(.GAP(4)) u_l2 (
        .clk(clk), .miss_valid(mv), .miss_slot(ms), .miss_line(ml),
        .refill_valid(fv), .refill_slot(fs), .refill_pair(fp),
        .refill_data(fd), .refill_last(fl), .busy(fb));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Refill pattern: each word holds its line address and word index
    function automatic logic [63:0] exp_d(input logic [31:0] a,
                                          input logic db);
        logic [31:0] e, o;
        e = {2'h0, a[31:5], a[4:3], 1'b0};
        o = {2'h0, a[31:5], a[4:3], 1'b1};
        return db ? {o, e} : (a[2] ? {o, 32'h0} : {32'h0, e});
    endfunction

    task automatic rd(input logic [31:0] a, input logic ns, ca, db, sq);
        @(negedge clk);
        rq = 1'b1;
        ra = a;
        rns = ns;
        rca = ca;
        rdb = db;
        rsq = sq;
        @(negedge clk);
        rq = 1'b0;
    endtask

    task automatic wait_fill();
        repeat (2) @(negedge clk);
        for (int i = 0; i < 60 && fb; i++) @(negedge clk);
        @(negedge clk);
    endtask

    task automatic rd_miss(input logic [31:0] a, input logic [26:0] l,
                           input logic d);
        rd(a, 1'b0, 1'b1, 1'b1, 1'b0);
        chk_flag(mv, 1'b1);
        chk(el, l);
        chk_flag(ed, d);
        wait_fill();
    endtask

    task automatic wr_st(input logic [31:0] a, input logic [63:0] d);
        @(negedge clk);
        chk_flag(wr, 1'b1);
        wq = 1'b1;
        wa = a;
        wd = d;
        @(negedge clk);
        wq = 1'b0;
    endtask

    task automatic lock(input logic [3:0] m, input logic sec);
        @(negedge clk);
        lsa = sec;
        lwr = 1'b1;
        lwd = m;
        @(negedge clk);
        lwr = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // Watchdog at about fifty times the expected run
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (3) @(negedge clk);
        chk({rv, mv, wh, lrd}, 64'h0);
        chk_flag(wr, 1'b1);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(rows[i].pa, rows[i].ns, rows[i].ca, rows[i].db, rows[i].sq);
            chk_flag(rv, 1'b1);
            chk_flag(rh, rows[i].hit);
            chk_flag(mv, rows[i].miss);
            if (rows[i].hit) begin
                chk(rdd, exp_d(rows[i].pa, rows[i].db));
                chk({ten, een, oen}, rows[i].en);
            end
            if (rows[i].miss) begin
                chk(ml, rows[i].pa[31:5]);
                chk(ms, 64'h0);
                wait_fill();
            end
        end
        wr_st(32'h400, 64'hc0de_0001);
        chk_flag(wh, 1'b1);
        // Read while the store still waits in the buffer
        rq = 1'b1;
        ra = 32'h400;
        rdb = 1'b1;
        @(negedge clk);
        rq = 1'b0;
        chk(rdd, exp_d(32'h404, 1'b0) | 64'hc0de_0001);
        wr_st(32'h1400, 64'h1);
        chk_flag(wh, 1'b0);
        rd_miss(32'h1400, 27'h20, 1'b1);
        lock(4'h2, 1'b1);
        lock(4'hf, 1'b0);
        chk(lrd, 64'h0);
        lsa = 1'b1;
        repeat (2) @(negedge clk);
        chk(lrd, 64'h2);
        lsh = 1'b1;
        lock(4'h6, 1'b0);
        chk(lrd, 64'h6);
        rd_miss(32'h1800, 27'h60, 1'b0);
        rd_miss(32'h1c00, 27'ha0, 1'b0);
        lock(4'hf, 1'b1);
        rd_miss(32'h2000, 27'he0, 1'b0);
        ens = 1'b0;
        rd(32'h2000, 1'b0, 1'b1, 1'b1, 1'b0);
        chk({rh, ten, een, oen, mv}, 64'h0);
        wr_st(32'h2000, 64'h5);
        chk_flag(wh, 1'b0);
        cns = 1'b1;
        enn = 1'b1;
        rd(32'h2000, 1'b0, 1'b1, 1'b1, 1'b0);
        chk_flag(rh, 1'b1);
        chk(rdd, exp_d(32'h2000, 1'b1));
        cns = 1'b0;
        ens = 1'b1;
        lock(4'h0, 1'b1);
        rrp = 1'b0;
        // Four back-to-back misses while no refill has come back
        @(negedge clk);
        for (int i = 1; i <= 4; i++) begin
            rq = 1'b1;
            ra = 32'(i) << 5;
            @(negedge clk);
            nm += int'(mv);
        end
        rq = 1'b0;
        chk(64'(nm), 64'h3);
        wait_fill();
        rd(32'h80, 1'b0, 1'b1, 1'b1, 1'b0);
        chk_flag(mv, 1'b1);
        wait_fill();
        rd(32'h20, 1'b0, 1'b1, 1'b1, 1'b0);
        chk(rdd, exp_d(32'h20, 1'b1));
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd(32'h2000, 1'b0, 1'b1, 1'b1, 1'b0);
        chk_flag(rh, 1'b0);
        finish_test();
    end
endmodule // l1c_cache_tb_top
`default_nettype wire
